//--- hdl/sce_consts.vh
/*
 Constants for the stepper command executor: command codes, move modes,
 status values and timing figures. Assumes a 20 MHz module clock.
*/
`ifndef SCE_CONSTS_VH
`define SCE_CONSTS_VH
`define SCE_CMD_IDLE 8'h00
`define SCE_CMD_MOVE 8'h7a
`define SCE_CMD_OFFSET 8'h7b
`define SCE_CMD_JOG_POS 8'h7c
`define SCE_CMD_JOG_NEG 8'h7d
`define SCE_CMD_SEEK 8'h7e
`define SCE_CMD_RELOAD 8'h7f
`define SCE_MODE_ABS 4'h0
`define SCE_MODE_REL 4'h1
`define SCE_MODE_CONT_P 4'h2
`define SCE_MODE_CONT_N 4'h3
`define SCE_MODE_MAN_P 4'h4
`define SCE_MODE_MAN_N 4'h5
`define SCE_STAT_BUSY 8'h00
`define SCE_STAT_DONE 8'h80
`define SCE_STAT_ERR 8'h81
`define SCE_CLK_HZ 20000000
`define SCE_JOG_HOLD_MS 500
`define SCE_CLR_MS 50
`define SCE_JOG_HOLD_CYC ((`SCE_CLK_HZ / 1000) * `SCE_JOG_HOLD_MS)
`define SCE_CLR_CYC ((`SCE_CLK_HZ / 1000) * `SCE_CLR_MS)
`define SCE_ST_IDLE 3'h0
`define SCE_ST_FETCH 3'h1
`define SCE_ST_RUN 3'h2
`define SCE_ST_STOP 3'h3
`define SCE_ST_CLR 3'h4
`define SCE_ST_CFGPTR 3'h5
`define SCE_ST_CFGBLK 3'h6
`define SCE_ST_DONE 3'h7
`endif

//--- hdl/sce_executor.v
/*
 Command executor of a stepper position module: decodes host command
 codes 122..127 and drives a pulse-motion engine and a counter clear.
 Assumes an external pulse generator that ramps toward a requested speed,
 counts travelled steps, reports stop, and a reference-point detector.
*/
// Summary of operation
// - Code 122 runs a motion chosen by the move mode field.
// - Modes 0 and 1 make one step move with commanded speed and position.
// - Modes 2 and 3 ignore position, run at speed until command goes idle.
// - Modes 4 and 5 track commanded speed continuously, ignoring position.
// - Code 123 stores position minus reference into offset, then zeroes position.
// - Code 124 jogs positive; released under 0.5 s moves the manual step distance.
// - Jog held 0.5 s or longer ramps toward manual travel speed.
// - Jog byte returning idle after a long hold decelerates the motor to a stop.
// - Code 125 is the same jog in the negative direction.
// - Code 126 seeks reference; when stopped, position loads the offset.
// - After a seek the counter clear output holds 50 ms.
// - Code 127 fetches table pointer, reads config block, applies changes.
// - Configuration reload invalidates every cached profile entry.
// - Move command never uses the cache; always reads fresh block.
// - Status 0x80 means done without error; larger means error.
`timescale 1ns/1ps
`default_nettype none
`include "sce_consts.vh"
module sce_executor #(
  parameter POS_W = 32,
  parameter SPD_W = 32,
  parameter CACHE_N = 4,
  parameter JOG_HOLD_CYC = `SCE_JOG_HOLD_CYC,
  parameter CLR_CYC = `SCE_CLR_CYC
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] cmd_byte,
  input wire [3:0] move_mode,
  input wire [SPD_W-1:0] cmd_speed,
  input wire [POS_W-1:0] cmd_position,
  input wire [POS_W-1:0] manual_step_distance,
  input wire [SPD_W-1:0] manual_speed,
  input wire [POS_W-1:0] reference_offset_in,
  input wire [POS_W-1:0] reference_point_pos,
  input wire [POS_W-1:0] present_position,
  input wire motion_stopped,
  input wire reference_point_found,
  input wire special_memory_ack,
  input wire [15:0] special_memory_data,
  input wire config_ack,
  input wire config_error,
  output reg [7:0] status_byte_r,
  output reg move_start_r,
  output reg move_stop_r,
  output reg move_dir_neg_r,
  output reg move_continuous_r,
  output reg [SPD_W-1:0] move_speed_r,
  output reg [POS_W-1:0] move_distance_r,
  output reg move_absolute_r,
  output reg seek_start_r,
  output reg pos_load_r,
  output reg [POS_W-1:0] pos_load_value_r,
  output reg offset_write_r,
  output reg [POS_W-1:0] reference_offset_r,
  output reg counter_clear_output_r,
  output reg special_memory_rd_r,
  output reg config_rd_r,
  output reg [15:0] config_addr_r,
  output reg [CACHE_N-1:0] cache_valid_r
);
  reg [2:0] state_r;
  reg [7:0] cmd_r;
  reg [3:0] mode_r;
  reg [31:0] timer_r;
  reg hold_long_r;
  reg [SPD_W-1:0] last_speed_r;
  wire cmd_idle = (cmd_byte == `SCE_CMD_IDLE);
  wire jog_cmd = (cmd_r == `SCE_CMD_JOG_POS) || (cmd_r == `SCE_CMD_JOG_NEG);
  wire valid_code = (cmd_byte >= `SCE_CMD_MOVE) && (cmd_byte <= `SCE_CMD_RELOAD);
  integer i;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= `SCE_ST_IDLE;
      cmd_r <= `SCE_CMD_IDLE;
      mode_r <= 4'h0;
      timer_r <= 32'h0;
      hold_long_r <= 1'b0;
      last_speed_r <= {SPD_W{1'b0}};
      status_byte_r <= `SCE_STAT_BUSY;
      move_start_r <= 1'b0;
      move_stop_r <= 1'b0;
      move_dir_neg_r <= 1'b0;
      move_continuous_r <= 1'b0;
      move_speed_r <= {SPD_W{1'b0}};
      move_distance_r <= {POS_W{1'b0}};
      move_absolute_r <= 1'b0;
      seek_start_r <= 1'b0;
      pos_load_r <= 1'b0;
      pos_load_value_r <= {POS_W{1'b0}};
      offset_write_r <= 1'b0;
      reference_offset_r <= {POS_W{1'b0}};
      counter_clear_output_r <= 1'b0;
      special_memory_rd_r <= 1'b0;
      config_rd_r <= 1'b0;
      config_addr_r <= 16'h0;
      cache_valid_r <= {CACHE_N{1'b0}};
    end else begin
      move_start_r <= 1'b0;
      move_stop_r <= 1'b0;
      seek_start_r <= 1'b0;
      pos_load_r <= 1'b0;
      offset_write_r <= 1'b0;
      case (state_r)
        `SCE_ST_IDLE: begin
          if (!cmd_idle) begin
            cmd_r <= cmd_byte;
            mode_r <= move_mode;
            status_byte_r <= `SCE_STAT_BUSY;
            timer_r <= 32'h0;
            hold_long_r <= 1'b0;
            if (!valid_code) begin
              status_byte_r <= `SCE_STAT_ERR;
              state_r <= `SCE_ST_DONE;
            end else begin
              state_r <= `SCE_ST_FETCH;
            end
          end
        end
        `SCE_ST_FETCH: begin
          state_r <= `SCE_ST_RUN;
          case (cmd_r)
            `SCE_CMD_MOVE: begin
              // Fresh block every time, no cache lookup
              move_speed_r <= cmd_speed;
              last_speed_r <= cmd_speed;
              move_distance_r <= cmd_position;
              move_absolute_r <= (mode_r == `SCE_MODE_ABS);
              move_continuous_r <= (mode_r > `SCE_MODE_REL);
              move_dir_neg_r <= (mode_r == `SCE_MODE_CONT_N) ||
                                (mode_r == `SCE_MODE_MAN_N);
              move_start_r <= 1'b1;
              if (mode_r > `SCE_MODE_MAN_N) begin
                move_start_r <= 1'b0;
                status_byte_r <= `SCE_STAT_ERR;
                state_r <= `SCE_ST_DONE;
              end
            end
            `SCE_CMD_OFFSET: begin
              reference_offset_r <= present_position - reference_point_pos;
              offset_write_r <= 1'b1;
              pos_load_value_r <= {POS_W{1'b0}};
              pos_load_r <= 1'b1;
              status_byte_r <= `SCE_STAT_DONE;
              state_r <= `SCE_ST_DONE;
            end
            `SCE_CMD_JOG_POS, `SCE_CMD_JOG_NEG: begin
              move_dir_neg_r <= (cmd_r == `SCE_CMD_JOG_NEG);
              move_absolute_r <= 1'b0;
              move_continuous_r <= 1'b0;
              move_speed_r <= manual_speed;
              move_distance_r <= manual_step_distance;
              move_start_r <= 1'b1;
            end
            `SCE_CMD_SEEK: begin
              seek_start_r <= 1'b1;
            end
            default: begin
              special_memory_rd_r <= 1'b1;
              state_r <= `SCE_ST_CFGPTR;
            end
          endcase
        end
        `SCE_ST_RUN: begin
          if (cmd_r == `SCE_CMD_MOVE) begin
            if (mode_r <= `SCE_MODE_REL) begin
              if (motion_stopped && !move_start_r) begin
                status_byte_r <= `SCE_STAT_DONE;
                state_r <= `SCE_ST_DONE;
              end
            end else if (cmd_idle) begin
              move_stop_r <= 1'b1;
              state_r <= `SCE_ST_STOP;
            end else if (mode_r >= `SCE_MODE_MAN_P && cmd_speed != last_speed_r) begin
              last_speed_r <= cmd_speed;
              move_speed_r <= cmd_speed;
            end
          end else if (jog_cmd) begin
            if (!hold_long_r) begin
              timer_r <= timer_r + 32'h1;
              if (cmd_idle) begin
                // Short press: step move already launched runs to its end
                hold_long_r <= 1'b1;
                state_r <= `SCE_ST_STOP;
              end else if (timer_r >= JOG_HOLD_CYC - 1) begin
                hold_long_r <= 1'b1;
                move_continuous_r <= 1'b1;
                move_speed_r <= manual_speed;
                move_start_r <= 1'b1;
              end
            end else if (cmd_idle) begin
              move_stop_r <= 1'b1;
              state_r <= `SCE_ST_STOP;
            end
          end else begin
            if (reference_point_found && motion_stopped && !seek_start_r) begin
              pos_load_value_r <= reference_offset_in;
              pos_load_r <= 1'b1;
              counter_clear_output_r <= 1'b1;
              timer_r <= 32'h0;
              state_r <= `SCE_ST_CLR;
            end
          end
        end
        `SCE_ST_STOP: begin
          if (motion_stopped && !move_stop_r && !move_start_r) begin
            move_continuous_r <= 1'b0;
            status_byte_r <= `SCE_STAT_DONE;
            state_r <= `SCE_ST_DONE;
          end
        end
        `SCE_ST_CLR: begin
          timer_r <= timer_r + 32'h1;
          if (timer_r >= CLR_CYC - 1) begin
            counter_clear_output_r <= 1'b0;
            status_byte_r <= `SCE_STAT_DONE;
            state_r <= `SCE_ST_DONE;
          end
        end
        `SCE_ST_CFGPTR: begin
          if (special_memory_ack) begin
            special_memory_rd_r <= 1'b0;
            config_addr_r <= special_memory_data;
            config_rd_r <= 1'b1;
            state_r <= `SCE_ST_CFGBLK;
          end
        end
        `SCE_ST_CFGBLK: begin
          if (config_ack) begin
            config_rd_r <= 1'b0;
            for (i = 0; i < CACHE_N; i = i + 1) begin
              cache_valid_r[i] <= 1'b0;
            end
            status_byte_r <= config_error ? `SCE_STAT_ERR : `SCE_STAT_DONE;
            state_r <= `SCE_ST_DONE;
          end
        end
        `SCE_ST_DONE: begin
          if (cmd_idle) begin
            cmd_r <= `SCE_CMD_IDLE;
            state_r <= `SCE_ST_IDLE;
          end
        end
        default: begin
          state_r <= `SCE_ST_IDLE;
        end
      endcase
    end
  end
endmodule // sce_executor
`default_nettype wire

//--- verification/sce_executor_assertions.sv
/* Checker for the stepper command executor ports.
 Assumes the bench holds position and jog inputs steady during a command. */
`timescale 1ns/1ps
`default_nettype none
module sce_executor_chk #(parameter POS_W = 32, parameter SPD_W = 32, parameter CACHE_N = 4,
    parameter CLR_CYC = 10) (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] cmd_byte,
  input wire [POS_W-1:0] manual_step_distance,
  input wire [SPD_W-1:0] manual_speed,
  input wire [POS_W-1:0] reference_offset_in,
  input wire [POS_W-1:0] reference_point_pos,
  input wire [POS_W-1:0] present_position,
  input wire [7:0] status_byte_r,
  input wire move_start_r,
  input wire move_stop_r,
  input wire move_dir_neg_r,
  input wire move_continuous_r,
  input wire [SPD_W-1:0] move_speed_r,
  input wire [POS_W-1:0] move_distance_r,
  input wire pos_load_r,
  input wire [POS_W-1:0] pos_load_value_r,
  input wire offset_write_r,
  input wire [POS_W-1:0] reference_offset_r,
  input wire counter_clear_output_r,
  input wire config_rd_r,
  input wire [CACHE_N-1:0] cache_valid_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [31:0] clr_cnt_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) clr_cnt_r <= 32'h0;
    else clr_cnt_r <= counter_clear_output_r ? clr_cnt_r + 32'h1 : 32'h0;
  end
  property p_offs; offset_write_r |-> pos_load_r && pos_load_value_r == '0; endproperty
  a_offs: assert property (p_offs) else $error("offset zero load wrong");
  property p_offv; offset_write_r |-> reference_offset_r == present_position - reference_point_pos; endproperty
  a_offv: assert property (p_offv) else $error("offset value wrong");
  property p_seek; pos_load_r && !offset_write_r |-> pos_load_value_r == reference_offset_in; endproperty
  a_seek: assert property (p_seek) else $error("seek load value wrong");
  property p_clr; $fell(counter_clear_output_r) |-> clr_cnt_r == CLR_CYC; endproperty
  a_clr: assert property (p_clr) else $error("clear width wrong");
  property p_jdir; move_start_r && cmd_byte[7:1] == 7'h3e |-> move_dir_neg_r == cmd_byte[0]; endproperty
  a_jdir: assert property (p_jdir) else $error("jog direction wrong");
  property p_jstep; move_start_r && !move_continuous_r && cmd_byte[7:1] == 7'h3e
    |-> move_distance_r == manual_step_distance; endproperty
  a_jstep: assert property (p_jstep) else $error("jog step wrong");
  property p_jrun; move_start_r && move_continuous_r && cmd_byte[7:1] == 7'h3e
    |-> move_speed_r == manual_speed; endproperty
  a_jrun: assert property (p_jrun) else $error("jog speed wrong");
  property p_stop; $fell(|cmd_byte) && move_continuous_r && status_byte_r == 8'h00
    |-> ##[1:3] move_stop_r; endproperty
  a_stop: assert property (p_stop) else $error("no stop on idle");
  property p_cache; config_rd_r ##1 !config_rd_r |-> cache_valid_r == '0; endproperty
  a_cache: assert property (p_cache) else $error("cache not cleared");
  c_off: cover property (offset_write_r);
  c_clr: cover property ($fell(counter_clear_output_r));
  c_stop: cover property (move_stop_r);
endmodule // sce_executor_chk
bind sce_executor sce_executor_chk #(.POS_W(POS_W), .SPD_W(SPD_W), .CACHE_N(CACHE_N),
    .CLR_CYC(CLR_CYC)) chk_i (.*);
`default_nettype wire

//--- verification/sce_motor_model.sv
/* Far-side model: pulse engine, seek detector, pointer and config memory.
 Assumes one-cycle start/stop pulses and read levels held until ack. */
`timescale 1ns/1ps
`default_nettype none
module sce_motor_model #(parameter logic [15:0] PTR = 16'h1234) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic move_start_r,
  input wire logic move_stop_r,
  input wire logic move_continuous_r,
  input wire logic seek_start_r,
  input wire logic special_memory_rd_r,
  input wire logic config_rd_r,
  input wire logic [3:0] dly,
  output logic motion_stopped,
  output logic reference_point_found,
  output logic special_memory_ack,
  output logic [15:0] special_memory_data,
  output logic config_ack,
  output logic config_error
);
  logic hold_r, run_r, seek_r;
  logic [3:0] cnt_r;
  wire logic ready = cnt_r >= dly;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {hold_r, run_r, seek_r, special_memory_ack, config_ack, reference_point_found} <= 6'h00;
      {config_error, cnt_r} <= 5'h00;
      motion_stopped <= 1'b1;
      special_memory_data <= 16'h0000;
    end else begin
      special_memory_ack <= special_memory_rd_r && ready && !special_memory_ack;
      config_ack <= config_rd_r && ready && !config_ack;
      special_memory_data <= (special_memory_rd_r && ready) ? PTR : ~PTR;
      cnt_r <= (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
      if (move_start_r || move_stop_r || seek_start_r || special_memory_ack || config_ack)
        cnt_r <= 4'h0;
      if (run_r && !hold_r && ready) {run_r, motion_stopped} <= 2'b01;
      if (move_start_r) {run_r, hold_r, motion_stopped} <= {1'b1, move_continuous_r, 1'b0};
      if (move_stop_r) hold_r <= 1'b0;
      if (seek_r && ready) {seek_r, reference_point_found, motion_stopped} <= 3'b011;
      if (seek_start_r) {seek_r, reference_point_found, motion_stopped} <= 3'b100;
    end
  end
endmodule // sce_motor_model
`default_nettype wire

//--- verification/sce_executor_bench.sv
/* Testbench for the stepper command executor.
 Assumes the far-side model answers reads, motion and seek. */
`timescale 1ns/1ps
`default_nettype none
module sce_executor_bench;
  localparam int JOG = 20;
  localparam int CLR = 10;
  localparam logic [15:0] PTR = 16'h2468;
  logic clk_sys = 1'b0;
  logic reset_n;
  logic [7:0] cmd_byte = 8'h00;
  logic [3:0] move_mode = 4'h0, dly = 4'h1;
  logic [31:0] cmd_speed = 32'h100, cmd_position = 32'h40, manual_step_distance = 32'h10;
  logic [31:0] manual_speed = 32'h200, reference_offset_in = 32'h33;
  logic [31:0] reference_point_pos = 32'h12c, present_position = 32'h3e8;
  wire motion_stopped, reference_point_found, special_memory_ack, config_ack, config_error;
  wire move_start_r, move_stop_r, move_dir_neg_r, move_continuous_r, move_absolute_r;
  wire seek_start_r, pos_load_r, offset_write_r, counter_clear_output_r;
  wire special_memory_rd_r, config_rd_r;
  wire [15:0] special_memory_data, config_addr_r;
  wire [7:0] status_byte_r;
  wire [3:0] cache_valid_r;
  wire [31:0] move_speed_r, move_distance_r, pos_load_value_r, reference_offset_r;
  int mismatches = 0, checks = 0, cyc = 0;
  sce_executor #(.JOG_HOLD_CYC(JOG), .CLR_CYC(CLR)) sce_executor_i (.*);
  sce_motor_model #(.PTR(PTR)) sce_motor_model_i (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic issue(input logic [7:0] c, input logic [3:0] m);
    @(negedge clk_sys);
    cmd_byte = c;
    move_mode = m;
    @(negedge clk_sys);
  endtask
  task automatic done(input logic [7:0] exp, input string nm);
    int n;
    n = 0;
    while (status_byte_r === 8'h00 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk(nm, {24'h0, exp}, {24'h0, status_byte_r});
  endtask
  task automatic idle;
    @(negedge clk_sys);
    cmd_byte = 8'h00;
    @(negedge clk_sys);
  endtask
  task automatic t_offset;
    issue(8'h7b, 4'h0);
    done(8'h80, "offset status");
    chk("offset", 32'h2bc, reference_offset_r);
    idle;
    $display("offset test done");
  endtask
  task automatic t_move;
    for (int m = 0; m < 6; m++) begin
      issue(8'h7a, m[3:0]);
      repeat (3) @(negedge clk_sys);
      chk("move speed", cmd_speed, move_speed_r);
      if (m < 2) begin
        chk("move abs", {31'h0, m == 0}, {31'h0, move_absolute_r});
        chk("move dist", cmd_position, move_distance_r);
        done(8'h80, "move status");
      end else begin
        chk("move dir", {31'h0, m[0]}, {31'h0, move_dir_neg_r});
        cmd_speed = 32'h180;
        repeat (3) @(negedge clk_sys);
        chk("move track", (m > 3) ? 32'h180 : 32'h100, move_speed_r);
        cmd_byte = 8'h00;
        done(8'h80, "run status");
        cmd_speed = 32'h100;
      end
      idle;
    end
    $display("move test done");
  endtask
  task automatic t_jog(input logic [7:0] c, input int hold);
    issue(c, 4'h0);
    repeat (hold) @(negedge clk_sys);
    chk("jog dir", {31'h0, c[0]}, {31'h0, move_dir_neg_r});
    chk("jog run", {31'h0, hold > JOG}, {31'h0, move_continuous_r});
    if (hold < JOG) chk("jog dist", manual_step_distance, move_distance_r);
    else chk("jog speed", manual_speed, move_speed_r);
    cmd_byte = 8'h00;
    done(8'h80, "jog status");
    @(negedge clk_sys);
    $display("jog test done");
  endtask
  task automatic t_seek;
    dly = 4'h8;
    issue(8'h7e, 4'h0);
    cmd_byte = 8'h7b;
    done(8'h80, "seek status");
    chk("clear low", 32'h0, {31'h0, counter_clear_output_r});
    chk("offset kept", 32'h2bc, reference_offset_r);
    idle;
    dly = 4'h1;
    $display("seek test done");
  endtask
  task automatic t_reload;
    issue(8'h7f, 4'h0);
    done(8'h80, "reload status");
    chk("cfg addr", {16'h0, PTR}, {16'h0, config_addr_r});
    chk("cache", 32'h0, {28'h0, cache_valid_r});
    idle;
    issue(8'h55, 4'h0);
    done(8'h81, "bad code");
    idle;
    issue(8'h7a, 4'h6);
    done(8'h81, "bad mode");
    idle;
    $display("reload test done");
  endtask
  initial begin
    reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    t_offset;
    t_move;
    t_jog(8'h7c, 2);
    t_jog(8'h7d, 2);
    t_jog(8'h7c, JOG + 6);
    t_jog(8'h7d, JOG + 6);
    t_seek;
    t_reload;
    final_report;
  end
endmodule // sce_executor_bench
`default_nettype wire
